// [pkg/epp_pkg.sv]
// constants, register map and carrier types for the eight pin port
// assumes a 32-bit apb slave on a 100 MHz clock
`default_nettype none
package epp_pkg;
    localparam int unsigned EPP_PINS = 8;      // pins on the port
    localparam int unsigned EPP_AW = 8;        // byte address bits decoded
    // register byte offsets
    localparam logic [7:0] EPP_OFF_LEVEL = 8'h00;
    localparam logic [7:0] EPP_OFF_DRIVE = 8'h04;
    localparam logic [7:0] EPP_OFF_ALT2 = 8'h0c;
    localparam logic [7:0] EPP_OFF_ALT3 = 8'h10;
    localparam logic [7:0] EPP_OFF_DRAIN = 8'h28;
    localparam logic [7:0] EPP_OFF_PULL = 8'h2c;
    localparam logic [7:0] EPP_OFF_INGATE = 8'h38;
    localparam logic [7:0] EPP_OFF_STAT = 8'h40;   // boot mode and irq status
    localparam logic [7:0] EPP_OFF_ICLR = 8'h44;   // write one to clear
    localparam logic [7:0] EPP_OFF_IEN = 8'h48;    // interrupt enable
    // reset values
    localparam logic [7:0] EPP_RST_ZERO = 8'h00;
    localparam logic [7:0] EPP_RST_PULL = 8'h01;   // pin zero pull-up on
    localparam logic [7:0] EPP_PIN0_MASK = 8'h01;  // pin zero bit
    // implemented alternate-select bits
    localparam logic [7:0] EPP_ALT2_MASK = 8'h30;
    localparam logic [7:0] EPP_ALT3_MASK = 8'h31;
    // status word layout
    localparam int unsigned EPP_STAT_BOOT_BIT = 8;   // 1 EPP_BOOT_CHIP boot, 0 single-chip boot
    localparam int unsigned EPP_STAT_CONF_BIT = 9;   // select conflict
    // boot modes
    typedef enum logic {EPP_BOOT_SINGLE, EPP_BOOT_CHIP} epp_boot_t;
    // pin pad bundle
    typedef struct packed {
        logic [7:0] out;     // driven level
        logic [7:0] oe;      // driver enable
        logic [7:0] pull;    // pull-up enable
        logic [7:0] in_en;   // input buffer enable
    } epp_pad_t;
    // alternate function routing
    typedef struct packed {
        logic [7:0] irq_in;   // gated pin levels to the interrupt controller
        logic [7:0] alt2;     // select register two
        logic [7:0] alt3;     // select register three
    } epp_alt_t;
endpackage
`default_nettype wire

// [design/epp_pin_cell.sv]
// one pin's pad steering: driver, open drain, input gate
// assumes inputs are synchronous to pclk
`timescale 1ns/1ps
`default_nettype none
module epp_pin_cell (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic latch,
    input wire logic drive_en,
    input wire logic open_drain,
    input wire logic alt_sel,
    input wire logic alt_out,
    input wire logic alt_oe,
    input wire logic in_gate,
    input wire logic pin_in,
    output logic pad_out,
    output logic pad_oe,
    output logic in_level
);
    logic lvl_d; // chosen output level
    logic en_d;  // chosen driver enable
    // alternate peripheral takes the driver when selected
    always_comb begin
        lvl_d = alt_sel ? alt_out : latch;
        en_d = alt_sel ? alt_oe : drive_en;
    end
    // open drain only ever drives low, so a high level releases the pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_out <= 1'b0;
            pad_oe <= 1'b0;
        end else begin
            pad_out <= open_drain ? 1'b0 : lvl_d;
            pad_oe <= en_d & ~(open_drain & lvl_d);
        end
    end
    // closed input gate reads as zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_level <= 1'b0;
        end else begin
            in_level <= pin_in & in_gate;
        end
    end
endmodule
`default_nettype wire

// [design/epp_port.sv]
// eight pin port with boot strap, apb register slave and pin interrupt
// assumes apb master on pclk; pads resolve pin from out/oe/pull
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Function
// - pin zero output only, others bidirectional
// - each pin direction set independently
// - alternate roles: interrupt, timer, boot mode
// - two select registers, zero means port
// - reset: pin zero pulled up, rest off
// - strap input and pull-up on in reset
// - strap sampled at reset release picks boot
// - pin interrupt follows input gate, forced off in deep stop
// - register offsets as mapped
// - level register bits 7-0, upper zero
// - drive enable bits, reset zero
// - open drain bit selects driver style
// - pin zero pull-up fixed at one
// - input gate bits 7-1, bit zero zero
module epp_port
    import epp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] pin_in,
    output epp_pad_t pad_q,
    input wire logic [7:0] alt_out,
    input wire logic [7:0] alt_oe,
    input wire logic deep_stop_mode,
    output epp_alt_t alt_q,
    output epp_boot_t boot_mode_q,
    output logic irq_q
);
    // software registers
    logic [7:0] latch_q;      // output latch
    logic [7:0] drive_q;      // drive enable bits
    logic [7:0] alt2_q;       // select two
    logic [7:0] alt3_q;       // select three
    logic [7:0] drain_q;      // open drain selects
    logic [7:0] pull_q;       // pull-up bits
    logic [7:0] ingate_q;     // input gate bits
    logic [7:0] istat_q;      // sticky rising-edge status
    logic [7:0] ien_q;        // interrupt enables
    logic conflict_q;         // sticky double select flag
    logic boot_done_q;        // strap taken
    logic [7:0] in_prev_q;    // previous gated levels
    // derived
    logic [7:0] cell_out;     // per-pin pad outputs
    logic [7:0] cell_oe;      // per-pin pad enables
    logic [7:0] in_lvl;       // gated pin levels
    logic [7:0] alt_any;      // pin in alternate role
    logic [7:0] irq_gate;     // input gate seen by interrupt path
    logic wr_en;              // apb write strobe
    logic rd_en;              // apb read strobe
    logic [7:0] addr;         // decoded byte offset
    logic mapped;             // address hits a register
    logic [31:0] rdata_d;     // read mux
    logic [7:0] wbyte;        // low write byte
    logic [7:0] rise;         // new edges on gated inputs
    logic [7:0] conflict_d;   // pins selected twice
    logic access_d; // setup cycle that the next edge answers
    logic wr_take; // write taken at the access edge
    logic wr_level; // write hits the output latch
    logic wr_drive; // write hits the drive enables
    logic wr_alt2; // write hits select two
    logic wr_alt3; // write hits select three
    logic wr_drain; // write hits the driver style bits
    logic wr_pull; // write hits the pull-up bits
    logic wr_ingate; // write hits the input gate bits
    logic wr_iclr; // write hits the status clear word
    logic wr_ien; // write hits the interrupt enables

    assign addr = paddr[EPP_AW-1:0];
    assign wbyte = pwdata[7:0];
    assign wr_en = psel & penable & pwrite & pstrb[0];
    assign rd_en = psel & penable & ~pwrite;
    assign alt_any = alt2_q | alt3_q;
    assign conflict_d = alt2_q & alt3_q;
    // edges come from the interrupt input, so deep stop freezes them too
    assign rise = alt_q.irq_in & ~in_prev_q;
    assign access_d = psel & ~penable;
    // a write lands only at the edge that samples pready high
    assign wr_take = wr_en & pready;
    assign wr_level = wr_take & (addr == EPP_OFF_LEVEL);
    assign wr_drive = wr_take & (addr == EPP_OFF_DRIVE);
    assign wr_alt2 = wr_take & (addr == EPP_OFF_ALT2);
    assign wr_alt3 = wr_take & (addr == EPP_OFF_ALT3);
    assign wr_drain = wr_take & (addr == EPP_OFF_DRAIN);
    assign wr_pull = wr_take & (addr == EPP_OFF_PULL);
    assign wr_ingate = wr_take & (addr == EPP_OFF_INGATE);
    assign wr_iclr = wr_take & (addr == EPP_OFF_ICLR);
    assign wr_ien = wr_take & (addr == EPP_OFF_IEN);

    // address decode; reserved holes answer with an error
    always_comb begin
        case (addr)
            EPP_OFF_LEVEL, EPP_OFF_DRIVE, EPP_OFF_ALT2, EPP_OFF_ALT3,
            EPP_OFF_DRAIN, EPP_OFF_PULL, EPP_OFF_INGATE, EPP_OFF_STAT,
            EPP_OFF_ICLR, EPP_OFF_IEN: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // interrupt path ignores select bits; frozen only in deep stop
    always_comb begin
        irq_gate = deep_stop_mode ? EPP_RST_ZERO : ingate_q;
    end

    // one cell per pin
    genvar gi;
    generate
        for (gi = 0; gi < EPP_PINS; gi++) begin : g_pin
            epp_pin_cell u_cell (
                .pclk(pclk),
                .presetn(presetn),
                .latch(latch_q[gi]),
                .drive_en(drive_q[gi]),
                .open_drain(drain_q[gi]),
                .alt_sel(alt_any[gi]),
                .alt_out(alt_out[gi]),
                .alt_oe(alt_oe[gi]),
                .in_gate(ingate_q[gi]),
                .pin_in(pin_in[gi]),
                .pad_out(cell_out[gi]),
                .pad_oe(cell_oe[gi]),
                .in_level(in_lvl[gi])
            );
        end
    endgenerate

    // read mux; unused upper bits stay zero
    always_comb begin
        rdata_d = '0;
        case (addr)
            EPP_OFF_LEVEL: rdata_d[7:0] =
                (in_lvl & ingate_q) | (latch_q & ~ingate_q);
            EPP_OFF_DRIVE: rdata_d[7:0] = drive_q;
            EPP_OFF_ALT2: rdata_d[7:0] = alt2_q;
            EPP_OFF_ALT3: rdata_d[7:0] = alt3_q;
            EPP_OFF_DRAIN: rdata_d[7:0] = drain_q;
            EPP_OFF_PULL: rdata_d[7:0] = pull_q;
            EPP_OFF_INGATE: rdata_d[7:0] = ingate_q;
            EPP_OFF_STAT: begin
                rdata_d[7:0] = istat_q;
                rdata_d[EPP_STAT_BOOT_BIT] = boot_mode_q;
                rdata_d[EPP_STAT_CONF_BIT] = conflict_q;
            end
            EPP_OFF_IEN: rdata_d[7:0] = ien_q;
            default: rdata_d = '0;
        endcase
    end

    // ready answers the cycle after setup: no wait states ever
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= access_d;
        end
    end

    // error response only for the holes of the map, alongside ready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= access_d & ~mapped;
        end
    end

    // read data stands only with ready; zero keeps the bus quiet
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else begin
            prdata <= (access_d & ~pwrite) ? rdata_d : '0;
        end
    end

    // output latch; driven only where the drive bit is set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_q <= EPP_RST_ZERO;
        end else if (wr_level) begin
            latch_q <= wbyte;
        end
    end

    // drive enables; all drivers off after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_q <= EPP_RST_ZERO;
        end else if (wr_drive) begin
            drive_q <= wbyte;
        end
    end

    // select two; unimplemented bits stay zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alt2_q <= EPP_RST_ZERO;
        end else if (wr_alt2) begin
            alt2_q <= wbyte & EPP_ALT2_MASK;
        end
    end

    // select three; unimplemented bits stay zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alt3_q <= EPP_RST_ZERO;
        end else if (wr_alt3) begin
            alt3_q <= wbyte & EPP_ALT3_MASK;
        end
    end

    // driver style: push-pull after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drain_q <= EPP_RST_ZERO;
        end else if (wr_drain) begin
            drain_q <= wbyte;
        end
    end

    // pull-ups; pin zero cannot be switched off, the strap needs it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pull_q <= EPP_RST_PULL;
        end else if (wr_pull) begin
            pull_q <= wbyte | EPP_PIN0_MASK;
        end
    end

    // input gates; pin zero has no input path in port use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ingate_q <= EPP_RST_ZERO;
        end else if (wr_ingate) begin
            ingate_q <= wbyte & ~EPP_PIN0_MASK;
        end
    end

    // interrupt enables for the edge status bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ien_q <= EPP_RST_ZERO;
        end else if (wr_ien) begin
            ien_q <= wbyte;
        end
    end

    // pad bundle; pin zero input stays off after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_q.out <= EPP_RST_ZERO;
            pad_q.oe <= EPP_RST_ZERO;
            pad_q.pull <= EPP_PIN0_MASK;
            pad_q.in_en <= EPP_PIN0_MASK;
        end else begin
            pad_q.out <= cell_out;
            pad_q.oe <= cell_oe;
            pad_q.pull <= pull_q;
            pad_q.in_en <= ingate_q;
        end
    end

    // boot strap taken at the first edge after release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_done_q <= 1'b0;
            boot_mode_q <= EPP_BOOT_CHIP;
        end else if (!boot_done_q) begin
            boot_done_q <= 1'b1;
            boot_mode_q <= pin_in[0] ? EPP_BOOT_CHIP
                                     : EPP_BOOT_SINGLE;
        end
    end

    // alternate routing to peripherals
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alt_q <= '0;
        end else begin
            alt_q.irq_in <= pin_in & irq_gate;
            alt_q.alt2 <= alt2_q;
            alt_q.alt3 <= alt3_q;
        end
    end

    // previous interrupt inputs; both reset low, so no false edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_prev_q <= EPP_RST_ZERO;
        end else begin
            in_prev_q <= alt_q.irq_in;
        end
    end

    // edge status: set wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_q <= EPP_RST_ZERO;
        end else if (wr_iclr) begin
            istat_q <= (istat_q & ~wbyte) | rise;
        end else begin
            istat_q <= istat_q | rise;
        end
    end

    // double select flag; a standing conflict beats its clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conflict_q <= 1'b0;
        end else if (wr_iclr) begin
            conflict_q <= (conflict_q & ~pwdata[EPP_STAT_CONF_BIT])
                          | (|conflict_d);
        end else begin
            conflict_q <= conflict_q | (|conflict_d);
        end
    end

    // level interrupt while any enabled status bit is set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(istat_q & ien_q);
        end
    end
endmodule
`default_nettype wire

// [dv/epp_board_model.sv]
// board side of the port: resolves each pin from pad, pull-up and
// external drive; assumes the bench never drives a pin the pad drives
`timescale 1ns/1ps
`default_nettype none
module epp_board_model
    import epp_pkg::*;
(
    input wire logic pclk,
    input wire epp_pad_t pad_q,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_in
);
    // floating pins wander every cycle so no stale level looks valid
    logic [7:0] float_q = 8'h55;
    always_ff @(posedge pclk) begin
        float_q <= ~float_q;
    end
    // pad driver first, then the board, then the pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pad_q.oe[i]) begin
                pin_in[i] = pad_q.out[i];
            end else if (ext_en[i]) begin
                pin_in[i] = ext_val[i];
            end else if (pad_q.pull[i]) begin
                pin_in[i] = 1'b1;
            end else begin
                pin_in[i] = float_q[i];
            end
        end
    end
endmodule
`default_nettype wire

// [dv/epp_port_monitor.sv]
// port checker: apb timing, read masks, pad and interrupt relations
// assumes one clock domain and presetn as async active-low reset
`timescale 1ns/1ps
`default_nettype none
module epp_port_monitor
    import epp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] pin_in,
    input wire epp_pad_t pad_q,
    input wire logic deep_stop_mode,
    input wire epp_alt_t alt_q,
    input wire epp_boot_t boot_mode_q
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic live_q; // high from the first edge after reset release
    logic mapped; // low byte of the address hits a register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            live_q <= 1'b0;
        end else begin
            live_q <= 1'b1;
        end
    end
    assign mapped = paddr[7:0] inside {EPP_OFF_LEVEL, EPP_OFF_DRIVE,
        EPP_OFF_ALT2, EPP_OFF_ALT3, EPP_OFF_DRAIN, EPP_OFF_PULL,
        EPP_OFF_INGATE, EPP_OFF_STAT, EPP_OFF_ICLR, EPP_OFF_IEN};
    sequence s_setup; psel && !penable; endsequence
    sequence s_done; psel && penable && pready; endsequence
    a_ready_next: assert property (s_setup |=> s_done)
        else $error("no ready after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_map: assert property (pready |-> pslverr == !mapped)
        else $error("error response on wrong address");
    a_upper_zero: assert property (pready && !pwrite &&
        paddr[7:0] != EPP_OFF_STAT |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_gate_bit0: assert property (pready && !pwrite &&
        paddr[7:0] == EPP_OFF_INGATE |-> !prdata[0])
        else $error("input gate bit zero reads one");
    a_pull_fixed: assert property (pad_q.pull[0])
        else $error("pin zero pull-up dropped");
    a_pin0_out: assert property (live_q |-> !pad_q.in_en[0])
        else $error("pin zero input enabled");
    a_stop_quiet: assert property ($past(deep_stop_mode) |->
        alt_q.irq_in == 8'h00)
        else $error("interrupt input live in deep stop");
    a_irq_pin: assert property (
        (alt_q.irq_in & ~$past(pin_in)) == 8'h00)
        else $error("interrupt input without pin level");
    a_boot_hold: assert property (live_q |=> $stable(boot_mode_q))
        else $error("boot mode changed after capture");
endmodule
bind epp_port epp_port_monitor i_epp_port_monitor (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pad_q(pad_q), .deep_stop_mode(deep_stop_mode),
    .alt_q(alt_q), .boot_mode_q(boot_mode_q));
`default_nettype wire

// [dv/epp_port_tb.sv]
// self-checking bench for the eight pin port
// assumes the board model resolves pins; apb master on pclk edges
`timescale 1ns/1ps
`default_nettype none
module epp_port_tb
    import epp_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_q;
    logic deep_stop_mode, er;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [3:0] pstrb; // tied: full-word writes only
    logic [7:0] pin_in, alt_out, alt_oe, ext_en, ext_val;
    epp_pad_t pad_q;
    epp_alt_t alt_q;
    epp_boot_t boot_mode_q;
    int errors, checked;
    epp_port i_epp_port (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pad_q(pad_q), .alt_out(alt_out), .alt_oe(alt_oe),
        .deep_stop_mode(deep_stop_mode), .alt_q(alt_q),
        .boot_mode_q(boot_mode_q), .irq_q(irq_q));
    epp_board_model i_epp_board_model (.pclk(pclk), .pad_q(pad_q),
        .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
    // 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic end_of_test;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // one apb transfer; waits for ready, then one idle cycle
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no cycle count assumed: only the watchdog ends a hung wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    // pads lag a write by two edges, the interrupt a pin change by
    // three; values are read before the edge's own update lands
    task automatic settle;
        repeat (5) @(posedge pclk);
    endtask
    // reset with the strap pin pulled up or held low by the board
    task automatic t_reset(input logic low, input epp_boot_t b);
        @(posedge pclk);
        presetn <= 1'b0;
        ext_en <= {7'h0, low};
        ext_val <= 8'h00;
        repeat (2) @(posedge pclk);
        chk({8'h0, pad_q.oe, pad_q.pull, pad_q.in_en}, 32'h0101);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        ext_en <= 8'h00;
        chk({31'h0, boot_mode_q}, {31'h0, b});
    endtask
    // reset values, writable bits, reserved holes
    task automatic t_regs;
        logic [7:0] off [7] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h28, 8'h2c,
            8'h38};
        logic [7:0] rst [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
            8'h01, 8'h00};
        logic [7:0] ful [7] = '{8'hff, 8'hff, 8'h30, 8'h31, 8'hff, 8'hff,
            8'hfe};
        // strap pulled high: boot bit set, no edges, no conflict
        rc(EPP_OFF_STAT, 32'h0000_0100);
        for (int i = 0; i < 7; i++) begin
            rc(off[i], {24'h0, rst[i]});
        end
        // each select cleared before the next, never two set at once
        for (int i = 0; i < 7; i++) begin
            wr(off[i], 32'hffff_ffff);
            rc(off[i], {24'h0, ful[i]});
            wr(off[i], 32'h0);
        end
        rc(EPP_OFF_PULL, 32'h01);
        for (int i = 0; i < 2; i++) begin
            wr(8'h08 + 8'(12 * i), 32'hffff_ffff);
            chk({31'h0, er}, 32'h1);
            rc(8'h08 + 8'(12 * i), 32'h0);
        end
    endtask
    // push-pull on pins 0 and 3, open drain on pins 1 and 2
    task automatic t_output;
        wr(EPP_OFF_DRAIN, 32'h06);
        wr(EPP_OFF_LEVEL, 32'h05);
        wr(EPP_OFF_DRIVE, 32'h0f);
        settle;
        chk({24'h0, pad_q.oe}, 32'h0b);
        chk({24'h0, pad_q.out & pad_q.oe}, 32'h01);
        // pins 0, 4, 5 handed to the idle alternate peripheral
        wr(EPP_OFF_ALT2, 32'h30);
        wr(EPP_OFF_ALT3, 32'h01);
        settle;
        chk({16'h0, alt_q.alt2, alt_q.alt3}, 32'h3001);
        chk({24'h0, pad_q.oe}, 32'h0a);
        wr(EPP_OFF_ALT2, 32'h0);
        wr(EPP_OFF_ALT3, 32'h0);
        wr(EPP_OFF_DRIVE, 32'h0);
        wr(EPP_OFF_DRAIN, 32'h0);
    endtask
    // gated pins read the pin, pin zero keeps the latch
    task automatic t_input;
        ext_en <= 8'hfe;
        ext_val <= 8'ha0;
        wr(EPP_OFF_INGATE, 32'hff);
        settle;
        rc(EPP_OFF_LEVEL, 32'ha1);
        chk({24'h0, alt_q.irq_in}, 32'ha0);
    endtask
    // rising pin 7 with a given enable, then enable, then clear
    task automatic t_irq(input logic stop, input logic [7:0] en);
        ext_val <= 8'h00;
        // only pin 7 is wanted, so the other inputs are gated off
        wr(EPP_OFF_INGATE, 32'h80);
        deep_stop_mode <= stop;
        wr(EPP_OFF_IEN, {24'h0, en});
        wr(EPP_OFF_ICLR, 32'hff);
        settle;
        chk({31'h0, irq_q}, 32'h0);
        ext_val <= 8'h80;
        settle;
        chk({31'h0, irq_q}, {31'h0, en[7] & ~stop});
        wr(EPP_OFF_IEN, 32'h80);
        settle;
        chk({31'h0, irq_q}, {31'h0, ~stop});
        wr(EPP_OFF_ICLR, 32'h80);
        settle;
        chk({31'h0, irq_q}, 32'h0);
    endtask
    // watchdog: the full run needs a few microseconds
    initial begin
        #50000;
        errors++;
        end_of_test;
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        alt_out = 8'h00;
        alt_oe = 8'h00;
        deep_stop_mode = 1'b0;
        ext_en = 8'h00;
        ext_val = 8'h00;
        errors = 0;
        checked = 0;
        t_reset(1'b0, EPP_BOOT_CHIP);
        t_regs;
        t_output;
        t_input;
        t_irq(1'b0, 8'h80);
        t_irq(1'b0, 8'h00);
        t_irq(1'b1, 8'h80);
        t_reset(1'b1, EPP_BOOT_SINGLE);
        end_of_test;
    end
endmodule
`default_nettype wire
